// File: design/ssfs_sequencer.sv
// Frame sequencer for a synchronous serial port, master and slave.
// Assumes a word source with valid/ready and static configuration
// while the port is enabled.
//
// What this block does
// - Words carry 4 to 16 bits as programmed, most significant bit first.
// - Serial clock rests at idle level; it toggles only inside a frame.
// - Phase clear captures on the first clock edge, phase set on second.
// - Idle: frame select high, transmit low, clock low unless polarity set.
// - Master drives the serial clock pad; slave leaves it undriven.
// - Enabled master with a queued word lowers frame select, enables output.
// - Phase clear: slave data at select fall, master half period later.
// - Polarity 0, phase 0: sample on rising, change on falling edges.
// - Phase set: data and first clock edge half period after select falls.
// - Polarity 0, phase 1: sample on falling, change on rising edges.
// - Polarity 1, phase 0: first edge falls; capture falling, launch rising.
// - Polarity 1, phase 1: clock starts falling; sample rising edges.
// - Frame select rises one clock period after the final capture.
// - Phase clear bursts pulse frame select high between words.
// - Phase set bursts keep frame select low between words.
// - Control format: 8 control bits, nothing received, then 4-16 bits.
// - Queued control byte starts a frame; MSB driven at select fall.
// - Control format keeps select low all frame; receive ignored at first.
// - Control bits latched rising; response driven falling, latched rising.
// - Single control frame: select up one period after last latch; word out.
// - Control bursts keep select low; byte follows; word out per frame.
// - As slave, first bit is sampled on first capture edge after select.
`timescale 1ns/1ps
module ssfs_sequencer (
  input wire logic clk, // System clock, 100 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic port_enable, // Port runs while high
  input wire logic master_mode, // High: master, low: slave
  input wire ssfs_pkg::ssfs_format_t frame_format, // SPI or control word
  input wire logic clock_polarity_select, // Idle level of clock
  input wire logic clock_phase_select, // Capture on second edge
  input wire logic [3:0] data_size, // Bits per word minus one
  input wire logic [7:0] half_period, // Half clock period minus one
  input wire logic [15:0] tx_data, // Word from transmit queue
  input wire logic tx_valid, // Transmit word present
  output logic tx_ready, // Word accepted when valid too
  output logic [15:0] rx_data, // Received word
  output logic rx_valid, // One-cycle pulse per word
  input wire logic serial_clock_line_in, // Clock pin level
  output logic serial_clock_line_out, // Clock pin drive value
  output logic serial_clock_line_oe, // Clock pin driven
  input wire logic frame_select_line_in, // Select pin level
  output logic frame_select_line_out, // Select pin drive value
  output logic frame_select_line_oe, // Select pin driven
  output logic serial_transmit_line_out, // Transmit pin value
  output logic serial_transmit_line_oe, // Transmit pin driven
  input wire logic serial_receive_line_in // Receive pin level
);
  typedef enum {ST_IDLE, ST_SETUP, ST_BIT, ST_TAIL, ST_GAP} ssfs_state_t;

  ssfs_state_t state, next_state;
  logic [7:0] div_cnt, next_div_cnt;
  logic half, next_half;
  logic [4:0] bit_idx, next_bit_idx;
  logic [15:0] shift_tx, next_shift_tx, shift_rx, next_shift_rx;
  logic [15:0] hold_word, next_hold_word, slave_word, next_slave_word;
  logic hold_full, next_hold_full, next_tx_ready;
  logic [15:0] next_rx_data;
  logic next_rx_valid;
  logic sclk_o, next_sclk, sclk_oe, next_sclk_oe;
  logic fss_o, next_fss, txd_o, next_txd, txoe_o, next_txoe;
  logic rxd_s1, rxd_s2, fss_s1, fss_s2, tog_s1, tog_s2, tog_s3;
  logic ctrl, pol_eff, sph_eff, tick, take, capture_ok, link_clear;
  logic [3:0] size_eff;
  logic [4:0] last_idx;
  logic [15:0] aligned, slave_rx_word;
  logic slave_toggle, slave_bit, link_clk;

  // ***************************************************************
  // Configuration decode
  // ***************************************************************
  // Control format always runs with polarity and phase clear
  always_comb
  begin
    ctrl = (frame_format == ssfs_pkg::SSFS_FMT_CTRL);
    pol_eff = ctrl ? 1'b0 : clock_polarity_select;
    sph_eff = ctrl ? 1'b0 : clock_phase_select;
    size_eff = (data_size < ssfs_pkg::SIZE_MIN) ? ssfs_pkg::SIZE_MIN
                                                : data_size;
    last_idx = ctrl ? ssfs_pkg::RESP_START + {1'b0, size_eff}
                    : {1'b0, size_eff};
    // MSB of the word lands in bit 15 of the shifter
    aligned = ctrl ? {hold_word[7:0], 8'h00}
                   : hold_word << (ssfs_pkg::SIZE_TOP - size_eff);
    capture_ok = !ctrl || (bit_idx >= ssfs_pkg::RESP_START);
    tick = (div_cnt == half_period);
  end

  // ***************************************************************
  // Slave engine on the partner's clock
  // ***************************************************************
  // Capture edge becomes the rising edge of the local link clock
  always_comb
  begin
    link_clk = serial_clock_line_in ^ pol_eff ^ sph_eff;
    link_clear = frame_select_line_in | master_mode | ~port_enable;
  end

  ssfs_link_slave u_slave (
    .link_clk(link_clk),
    .reset(reset),
    .frame_clear(link_clear),
    .phase_select(sph_eff),
    .size(size_eff),
    .tx_word(slave_word),
    .rx_pin(serial_receive_line_in),
    .rx_word(slave_rx_word),
    .word_toggle(slave_toggle),
    .tx_bit(slave_bit)
  );

  // Slave transmit follows the partner's clock, so it cannot be retimed
  always_comb
  begin
    serial_transmit_line_out = master_mode ? txd_o : slave_bit;
    serial_transmit_line_oe = master_mode ? txoe_o
                              : (port_enable & ~frame_select_line_in);
  end

  // ***************************************************************
  // Sequencer next state
  // ***************************************************************
  always_comb
  begin
    next_state = state;
    next_div_cnt = (state == ST_IDLE || tick) ? ssfs_pkg::DIV_RST
                                              : div_cnt + 8'h01;
    next_half = half;
    next_bit_idx = bit_idx;
    next_shift_tx = shift_tx;
    next_shift_rx = shift_rx;
    next_rx_data = rx_data;
    next_rx_valid = 1'b0;
    next_sclk = sclk_o;
    next_sclk_oe = master_mode & port_enable;
    next_fss = fss_o;
    next_txd = txd_o;
    next_txoe = txoe_o;
    next_slave_word = slave_word;
    take = 1'b0;
    unique case (state)
      ST_IDLE:
      begin
        next_fss = 1'b1;
        next_sclk = pol_eff;
        next_txd = 1'b0;
        next_txoe = 1'b0;
        if (port_enable && master_mode && hold_full)
        begin
          take = 1'b1;
          next_state = ST_SETUP;
          next_fss = 1'b0;
          next_txoe = 1'b1;
          next_txd = ctrl ? hold_word[7] : 1'b0;
          next_shift_tx = aligned;
          next_shift_rx = ssfs_pkg::WORD_RST;
        end
      end
      ST_SETUP:
      begin
        // Half a period after select falls: data out, phase set edge
        if (tick)
        begin
          next_state = ST_BIT;
          next_half = 1'b0;
          next_bit_idx = ssfs_pkg::BIT_RST;
          next_txd = shift_tx[15];
          next_sclk = pol_eff ^ sph_eff;
        end
      end
      ST_BIT:
      begin
        if (tick && !half)
        begin
          // Middle of a bit: capture edge for every mode
          next_half = 1'b1;
          next_sclk = pol_eff ^ ~sph_eff;
          if (capture_ok)
            next_shift_rx = {shift_rx[14:0], rxd_s2};
        end
        else if (tick && bit_idx != last_idx)
        begin
          // End of a bit: launch edge shifts out the next bit
          next_half = 1'b0;
          next_bit_idx = bit_idx + 5'h01;
          next_shift_tx = shift_tx << 1;
          next_txd = shift_tx[14];
          next_sclk = pol_eff ^ sph_eff;
        end
        else if (tick && hold_full && port_enable)
        begin
          next_half = 1'b0;
          next_rx_data = shift_rx;
          next_rx_valid = 1'b1;
          if (!ctrl && !sph_eff)
          begin
            next_state = ST_GAP;
            next_fss = 1'b1;
            next_sclk = pol_eff;
            // Transmit rests low and undriven while select is high
            next_txoe = 1'b0;
            next_txd = 1'b0;
          end
          else
          begin
            // Next word follows with select held low
            take = 1'b1;
            next_bit_idx = ssfs_pkg::BIT_RST;
            next_shift_tx = aligned;
            next_shift_rx = ssfs_pkg::WORD_RST;
            next_txd = aligned[15];
            next_sclk = pol_eff ^ sph_eff;
          end
        end
        else if (tick)
        begin
          next_half = 1'b0;
          next_state = ST_TAIL;
          next_sclk = pol_eff;
        end
      end
      ST_TAIL:
      begin
        // Select rises one full period after the last capture
        if (tick)
        begin
          next_state = ST_IDLE;
          next_fss = 1'b1;
          next_txoe = 1'b0;
          next_txd = 1'b0;
          next_rx_data = shift_rx;
          next_rx_valid = 1'b1;
        end
      end
      ST_GAP:
      begin
        if (tick)
        begin
          take = 1'b1;
          next_state = ST_SETUP;
          next_fss = 1'b0;
          next_txoe = 1'b1;
          next_txd = 1'b0;
          next_shift_tx = aligned;
          next_shift_rx = ssfs_pkg::WORD_RST;
        end
      end
    endcase
    // Disable or mode change abandons the frame at once
    if (state != ST_IDLE && (!port_enable || !master_mode))
    begin
      next_state = ST_IDLE;
      next_fss = 1'b1;
      next_sclk = pol_eff;
      next_txd = 1'b0;
      next_txoe = 1'b0;
      take = 1'b0;
    end
    // Slave takes a fresh word only while no frame is selected
    if (!master_mode && port_enable && hold_full && fss_s2)
    begin
      take = 1'b1;
      next_slave_word = hold_word;
    end
    if (tog_s2 != tog_s3)
    begin
      next_rx_data = slave_rx_word;
      next_rx_valid = 1'b1;
    end
    // One-word holding stage in front of the shifter
    next_hold_word = hold_word;
    next_hold_full = hold_full & ~take;
    if (tx_valid && tx_ready)
    begin
      next_hold_word = tx_data;
      next_hold_full = 1'b1;
    end
    next_tx_ready = ~next_hold_full;
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  // Sequencer state and pin drive values
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      div_cnt <= ssfs_pkg::DIV_RST;
      half <= 1'b0;
      bit_idx <= ssfs_pkg::BIT_RST;
      shift_tx <= ssfs_pkg::WORD_RST;
      shift_rx <= ssfs_pkg::WORD_RST;
      hold_word <= ssfs_pkg::WORD_RST;
      hold_full <= 1'b0;
      slave_word <= ssfs_pkg::WORD_RST;
      tx_ready <= 1'b0;
      rx_data <= ssfs_pkg::WORD_RST;
      rx_valid <= 1'b0;
      sclk_o <= 1'b0;
      sclk_oe <= 1'b0;
      fss_o <= 1'b1;
      txd_o <= 1'b0;
      txoe_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      div_cnt <= next_div_cnt;
      half <= next_half;
      bit_idx <= next_bit_idx;
      shift_tx <= next_shift_tx;
      shift_rx <= next_shift_rx;
      hold_word <= next_hold_word;
      hold_full <= next_hold_full;
      slave_word <= next_slave_word;
      tx_ready <= next_tx_ready;
      rx_data <= next_rx_data;
      rx_valid <= next_rx_valid;
      sclk_o <= next_sclk;
      sclk_oe <= next_sclk_oe;
      fss_o <= next_fss;
      txd_o <= next_txd;
      txoe_o <= next_txoe;
    end
  end

  // Pin and link-domain synchronisers, two stages each; the link toggle has a third stage for edge detect
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      {rxd_s1, rxd_s2, fss_s1, fss_s2} <= 4'h3;
      {tog_s1, tog_s2, tog_s3} <= 3'h0;
    end
    else
    begin
      rxd_s1 <= serial_receive_line_in;
      rxd_s2 <= rxd_s1;
      fss_s1 <= frame_select_line_in;
      fss_s2 <= fss_s1;
      tog_s1 <= slave_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  // Master drives select and clock; slave leaves both to the partner
  always_comb
  begin
    serial_clock_line_out = sclk_o;
    serial_clock_line_oe = sclk_oe;
    frame_select_line_out = fss_o;
    frame_select_line_oe = sclk_oe;
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_word_end;
    state == ST_BIT && tick && half && bit_idx == last_idx;
  endsequence

  chk_idle_levels: assert property (
    state == ST_IDLE |-> fss_o && !txd_o && sclk_o == $past(pol_eff))
    else $error("idle levels wrong");
  chk_clock_pad: assert property (
    $past(!master_mode) |-> !serial_clock_line_oe)
    else $error("slave drives clock pad");
  chk_frame_start: assert property (
    state == ST_IDLE && port_enable && master_mode && hold_full
    |=> !fss_o && txoe_o && state == ST_SETUP)
    else $error("frame start missing");
  chk_setup_idle: assert property (
    state == ST_SETUP |-> sclk_o == pol_eff)
    else $error("clock moved before first bit");
  chk_bit_clock: assert property (
    state == ST_BIT && $past(state) == ST_BIT && $past(!tick)
    |-> sclk_o == (pol_eff ^ half ^ sph_eff))
    else $error("clock level off phase");
  chk_tail_select: assert property (
    s_word_end ##0 master_mode && port_enable && !hold_full
    |=> state == ST_TAIL && !fss_o && sclk_o == pol_eff)
    else $error("select left frame early");
  chk_gap_pulse: assert property (
    s_word_end ##0 master_mode && hold_full && port_enable && !ctrl && !sph_eff
    |=> fss_o ##1 (fss_o throughout (state == ST_GAP)[*1]))
    else $error("no select pulse between words");
  chk_burst_low: assert property (
    s_word_end ##0 master_mode && hold_full && port_enable && (ctrl || sph_eff)
    |=> !fss_o && state == ST_BIT && bit_idx == 5'h00)
    else $error("select rose inside burst");
  chk_ctrl_quiet: assert property (
    state == ST_BIT && ctrl && bit_idx < ssfs_pkg::RESP_START
    |=> $stable(shift_rx) || $past(state) != ST_BIT)
    else $error("captured during control byte");
  chk_word_out: assert property (
    state == ST_TAIL && tick |=> rx_valid && fss_o && state == ST_IDLE)
    else $error("word not delivered at frame end");
endmodule

// File: inc/ssfs_pkg.sv
// Constants shared by the frame sequencer and its link-side slave engine.
// Assumes a 100 MHz system clock and a serial word of 4 to 16 bits.
package ssfs_pkg;
  // ***************************************************************
  // Word geometry
  // ***************************************************************
  localparam int unsigned WORD_W = 16;
  localparam logic [3:0] SIZE_MIN = 4'h3;
  localparam logic [3:0] SIZE_TOP = 4'hf;
  // Control byte plus one decode wait bit before the response
  localparam logic [4:0] RESP_START = 5'h09;
  localparam logic [4:0] CTRL_MSB = 5'h07;

  // ***************************************************************
  // Values after reset
  // ***************************************************************
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [4:0] BIT_RST = 5'h00;

  // Frame formats
  typedef enum logic {SSFS_FMT_SPI, SSFS_FMT_CTRL} ssfs_format_t;
endpackage

// File: design/ssfs_link_slave.sv
// Slave-side shifter clocked by the partner's serial clock.
// Assumes link_clk rises on the capture edge and that frame_clear is
// high while no frame is selected.
`timescale 1ns/1ps
module ssfs_link_slave (
  input wire logic link_clk, // Capture-edge clock from the pin
  input wire logic reset, // Async hold of the word toggle
  input wire logic frame_clear, // High outside a frame
  input wire logic phase_select, // Capture on second edge
  input wire logic [3:0] size, // Bits per word minus one
  input wire logic [15:0] tx_word, // Word to send, held stable
  input wire logic rx_pin, // Serial receive line
  output logic [15:0] rx_word, // Last complete received word
  output logic word_toggle, // Flips once per received word
  output logic tx_bit // Bit to present on transmit
);
  logic [4:0] cap_cnt, next_cap_cnt;
  logic [15:0] rx_sh, next_rx_sh, next_rx_word;
  logic next_toggle;
  logic [4:0] lch_cnt, next_lch_cnt;
  logic launch_bit, next_launch_bit;
  logic [4:0] lch_idx;

  // ***************************************************************
  // Capture side
  // ***************************************************************
  // Shift in on each capture edge; hand over the word at its last bit
  always_comb
  begin
    next_rx_sh = {rx_sh[14:0], rx_pin};
    next_cap_cnt = cap_cnt + 5'h01;
    next_rx_word = rx_word;
    next_toggle = word_toggle;
    if (cap_cnt == {1'b0, size})
    begin
      next_cap_cnt = ssfs_pkg::BIT_RST;
      next_rx_word = next_rx_sh;
      next_toggle = ~word_toggle;
    end
  end

  // Frame select high clears the count, so a new frame starts at bit 0
  always_ff @(posedge link_clk or posedge frame_clear)
  begin
    if (frame_clear)
    begin
      cap_cnt <= ssfs_pkg::BIT_RST;
      rx_sh <= ssfs_pkg::WORD_RST;
    end
    else
    begin
      cap_cnt <= next_cap_cnt;
      rx_sh <= next_rx_sh;
    end
  end

  // Word and toggle survive frame select so the crossing sees every word
  always_ff @(posedge link_clk or posedge reset)
  begin
    if (reset)
    begin
      rx_word <= ssfs_pkg::WORD_RST;
      word_toggle <= 1'b0;
    end
    else
    begin
      rx_word <= next_rx_word;
      word_toggle <= next_toggle;
    end
  end

  // ***************************************************************
  // Launch side
  // ***************************************************************
  // Phase clear shows the MSB at frame start; later bits follow edges
  always_comb
  begin
    lch_idx = {1'b0, size} - lch_cnt - {4'h0, ~phase_select};
    next_launch_bit = lch_idx[4] ? 1'b0 : tx_word[lch_idx[3:0]];
    next_lch_cnt = (lch_cnt == {1'b0, size}) ? ssfs_pkg::BIT_RST
                                             : lch_cnt + 5'h01;
    tx_bit = (!phase_select && lch_cnt == ssfs_pkg::BIT_RST)
             ? tx_word[size] : launch_bit;
  end

  // Launch happens on the edge opposite to capture
  always_ff @(negedge link_clk or posedge frame_clear)
  begin
    if (frame_clear)
    begin
      lch_cnt <= ssfs_pkg::BIT_RST;
      launch_bit <= 1'b0;
    end
    else
    begin
      lch_cnt <= next_lch_cnt;
      launch_bit <= next_launch_bit;
    end
  end
endmodule

// File: tb/ssfs_peer.sv
// Far-side serial device: shifts a response out, captures the line in.
// Assumes static mode inputs while its select is low.
`timescale 1ns/1ps
module ssfs_peer (
  input wire logic sclk, // Serial clock wire
  input wire logic sel_n, // Frame select wire
  input wire logic mosi, // Data from the sequencer
  input wire logic pol, // Idle clock level
  input wire logic pha, // Capture on second edge
  input wire logic ctrl, // Control-word format
  input wire logic [3:0] size, // Bits minus one
  input wire logic [15:0] resp, // Word to send back
  output logic miso // Data to the sequencer
);
  logic [15:0] sh;
  logic [15:0] gotq[$];
  logic [4:0] cnt;
  logic [4:0] k;
  realtime t_cap;
  wire cap = sclk ^ pol ^ pha;
  wire [4:0] off = ctrl ? 5'h09 : 5'h00;
  initial
  begin
    miso = 1'b0;
    cnt = 5'h00;
    sh = 16'h0000;
    t_cap = 0;
  end
  // Frame start: phase clear shows the MSB at once
  always @(negedge sel_n)
  begin
    cnt = 5'h00;
    sh = 16'h0000;
    if (!pha && !ctrl) miso = resp[size];
  end
  // Capture edge; word ends after the response bits
  always @(posedge cap) if (!sel_n)
  begin
    sh = {sh[14:0], mosi};
    cnt = cnt + 5'h01;
    t_cap = $realtime;
    if (ctrl && cnt == 5'h08) gotq.push_back({8'h00, sh[7:0]});
    if (cnt == {1'b0, size} + 5'h01 + off)
    begin
      if (!ctrl) gotq.push_back(sh);
      cnt = 5'h00;
      sh = 16'h0000;
    end
  end
  // Launch edge; one wait bit after the control byte, else line junk
  always @(negedge cap) if (!sel_n)
  begin
    k = cnt - off;
    if (cnt >= off && k <= {1'b0, size})
      miso = resp[size - k[3:0]];
    else miso = ~miso;
  end
  // Released line at select rise shows no stale value
  always @(posedge sel_n) miso = ~miso;
endmodule

// File: tb/ssfs_sequencer_tb.sv
// Testbench for the frame sequencer against the far-side peer.
// Assumes half_period 2, so one serial clock period is 6 clk cycles.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  mismatches++; $display("BAD %s exp %h got %h", nm, e, g); end end
module ssfs_sequencer_tb;
  logic clk, reset, port_enable, master_mode, pol, pha, tx_valid;
  ssfs_pkg::ssfs_format_t fmt;
  logic [3:0] size;
  logic [15:0] tx_data, resp, rx_data;
  logic tx_ready, rx_valid, sc_out, sc_oe, fs_out, fs_oe, td_out, td_oe;
  logic m_sclk, m_fss, m_mosi, miso, watch;
  int mismatches, compares, rises, last_dt;
  logic [15:0] rxq[$];
  // Serial clock period in clk cycles; half periods of 3 clk cycles let
  // the two-stage receive synchroniser settle before the capture edge
  localparam int PER = 6;
  wire sclk_w = sc_oe ? sc_out : m_sclk;
  wire fss_w = fs_oe ? fs_out : m_fss;
  wire rx_w = master_mode ? miso : m_mosi;
  ssfs_sequencer u_ssfs_sequencer (.clk(clk), .reset(reset),
    .port_enable(port_enable), .master_mode(master_mode),
    .frame_format(fmt), .clock_polarity_select(pol),
    .clock_phase_select(pha), .data_size(size), .half_period(8'h02),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid),
    .serial_clock_line_in(sclk_w), .serial_clock_line_out(sc_out),
    .serial_clock_line_oe(sc_oe), .frame_select_line_in(fss_w),
    .frame_select_line_out(fs_out), .frame_select_line_oe(fs_oe),
    .serial_transmit_line_out(td_out), .serial_transmit_line_oe(td_oe),
    .serial_receive_line_in(rx_w));
  ssfs_peer u_ssfs_peer (.sclk(sclk_w), .sel_n(fss_w), .mosi(td_out),
    .pol(pol), .pha(pha), .ctrl(fmt == ssfs_pkg::SSFS_FMT_CTRL),
    .size(size), .resp(resp), .miso(miso));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Collect received words
  always @(posedge clk) if (rx_valid) rxq.push_back(rx_data);
  // Idle levels and output enable while a master run is watched
  always @(negedge clk) if (watch)
  begin
    if (fss_w) `CHK("idle clk", pol, sclk_w)
    if (fss_w) `CHK("idle tx", 1'b0, td_out)
    `CHK("tx oe", ~fs_out, td_oe)
  end
  // Select rises: count them, time the last one from the last capture
  always @(posedge fss_w) if (watch)
  begin
    rises++;
    last_dt = int'(($realtime - u_ssfs_peer.t_cap) / 10.0);
  end
  task automatic test_done();
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic offer(input logic [15:0] w);
    int i;
    tx_data = w;
    tx_valid = 1'b1;
    for (i = 0; i < 400 && tx_ready !== 1'b1; i++) @(negedge clk);
    if (i == 400)
    begin
      mismatches++;
      test_done();
    end
    @(negedge clk);
    tx_valid = 1'b0;
    @(negedge clk);
  endtask
  task automatic wait_rx(input int n);
    int i;
    for (i = 0; i < 2000 && rxq.size() < n; i++) @(negedge clk);
    if (i == 2000)
    begin
      mismatches++;
      test_done();
    end
    repeat (8) @(negedge clk);
  endtask
  task automatic setup(input logic ms, input ssfs_pkg::ssfs_format_t f,
    input logic p, input logic h, input logic [3:0] s);
    watch = 1'b0;
    port_enable = 1'b0;
    master_mode = ms;
    fmt = f;
    pol = p;
    pha = h;
    size = s;
    rxq.delete();
    u_ssfs_peer.gotq.delete();
    rises = 0;
    repeat (3) @(negedge clk);
    port_enable = 1'b1;
    repeat (2) @(negedge clk);
    watch = ms;
  endtask
  // Four clock modes, two words back to back, sizes at both ends
  task automatic t_spi_modes();
    logic [3:0] sz[4] = '{4'h3, 4'hf, 4'h7, 4'hb};
    logic [15:0] mk;
    int m;
    for (m = 0; m < 4; m++)
    begin
      setup(1'b1, ssfs_pkg::SSFS_FMT_SPI, m[1], m[0], sz[m]);
      `CHK("clk oe", 1'b1, sc_oe)
      resp = 16'h9e37 ^ 16'(m);
      mk = 16'hffff >> (4'hf - sz[m]);
      offer(16'ha5c3);
      offer(16'h5a3c);
      wait_rx(2);
      `CHK("peer w0", 16'ha5c3 & mk, u_ssfs_peer.gotq[0])
      `CHK("peer w1", 16'h5a3c & mk, u_ssfs_peer.gotq[1])
      `CHK("rx w0", resp & mk, rxq[0])
      `CHK("rx w1", resp & mk, rxq[1])
      `CHK("fss rises", m[0] ? 1 : 2, rises)
      `CHK("fss tail", PER, last_dt)
    end
  endtask
  // Control format: single 13-bit frame, then a 25-bit burst of two
  task automatic t_ctrl();
    setup(1'b1, ssfs_pkg::SSFS_FMT_CTRL, 1'b0, 1'b0, 4'h3);
    resp = 16'h000a;
    offer(16'h00c6);
    wait_rx(1);
    `CHK("ctrl byte", 16'h00c6, u_ssfs_peer.gotq[0])
    `CHK("ctrl rx", 16'h000a, rxq[0])
    `CHK("ctrl tail", PER, last_dt)
    setup(1'b1, ssfs_pkg::SSFS_FMT_CTRL, 1'b0, 1'b0, 4'hf);
    resp = 16'hb29d;
    offer(16'h0081);
    offer(16'h00f0);
    wait_rx(2);
    `CHK("burst b1", 16'h00f0, u_ssfs_peer.gotq[1])
    `CHK("burst rx", 16'hb29d, rxq[0])
    `CHK("burst rx2", 16'hb29d, rxq[1])
    `CHK("burst rises", 1, rises)
  endtask
  // Slave mode with a 160 ns link clock from the bench
  task automatic t_slave();
    logic [7:0] w = 8'h3b;
    logic [7:0] got;
    int i;
    setup(1'b0, ssfs_pkg::SSFS_FMT_SPI, 1'b0, 1'b0, 4'h7);
    `CHK("slave clk oe", 1'b0, sc_oe)
    offer(16'h0096);
    #3 m_fss = 1'b0;
    #320; // select setup before the first sampling edge
    for (i = 7; i >= 0; i--)
    begin
      m_mosi = w[i];
      #80 got[i] = td_out;
      m_sclk = 1'b1;
      #80 m_sclk = 1'b0;
    end
    #80 m_fss = 1'b1;
    wait_rx(1);
    `CHK("slave tx", 8'h96, got)
    `CHK("slave rx", w, rxq[0][7:0])
  endtask
  initial
  begin
    {reset, port_enable, master_mode, pol, pha, tx_valid} = 6'h20;
    {m_sclk, m_fss, m_mosi, watch} = 4'h4;
    fmt = ssfs_pkg::SSFS_FMT_SPI;
    size = 4'h7;
    tx_data = 16'h0000;
    resp = 16'h0000;
    mismatches = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    `CHK("rst fss", 1'b1, fs_out)
    `CHK("rst tx", 2'h0, {td_out, td_oe})
    t_spi_modes();
    t_ctrl();
    t_slave();
    test_done();
  end
endmodule
